// File: inc/irf_pkg.sv
// Purpose: Shared constants and types for the idle mode and reset flag block
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package irf_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS      = 4;
	localparam int CPU_START_DELAY_NS = 20;
	localparam int CSD_CYC = (CPU_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OST_CYC = 1024;
	localparam int TMR_W   = 11;

	// Register offsets
	localparam logic [7:0] RCTL_OFS = 8'h00;
	localparam logic [7:0] PCTL_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;

	// reset_control_reg fields
	localparam int BIT_IRQ_PRIORITY_ENABLE = 7;
	localparam int BIT_CM   = 5;
	localparam int BIT_RI   = 4;
	localparam int BIT_TO   = 3;
	localparam int BIT_PD   = 2;
	localparam int BIT_POR  = 1;
	localparam int BIT_BOR  = 0;
	localparam logic [7:0] RCTL_RST   = 8'h3c;
	localparam logic [7:0] RCTL_WMASK = 8'hb3;

	// power_control fields
	localparam int PC_SCS_LSB  = 0;
	localparam int PC_IDLE_ON_SLEEP_SELECT    = 2;
	localparam int PC_SOSC_EN  = 3;
	localparam int PC_WDT_EN   = 4;
	localparam int PC_FSCM_EN  = 5;
	localparam int PC_PRIMARY_OSC_CONFIG_LSB = 6;
	localparam logic [7:0] PCTL_RST = 8'h02;

	// system_clock_select codes
	localparam logic [1:0] SCS_RC  = 2'h0;
	localparam logic [1:0] SCS_SEC = 2'h1;
	localparam logic [1:0] SCS_PRI = 2'h2;

	// primary_osc_config codes
	localparam logic [1:0] PRIMARY_OSC_CONFIG_EC    = 2'h2;
	localparam logic [1:0] PRIMARY_OSC_CONFIG_EXTERNAL_CLOCK_PLL_MODE = 2'h3;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		M_RUN      = 3'h0,
		M_SEC_WAIT = 3'h1,
		M_IDLE     = 3'h2,
		M_SLEEP    = 3'h3,
		M_OST      = 3'h4,
		M_CSD      = 3'h5
	} irf_mode_t;

	typedef enum logic [1:0] {
		SRC_RC  = 2'h0,
		SRC_SEC = 2'h1,
		SRC_PRI = 2'h2
	} irf_src_t;

endpackage : irf_pkg

// File: design/irf_delay_timer.sv
// Purpose: Down counter for start-up and CPU start delays
// Assumes: start is a one-cycle pulse, load at least one
// Notes:   done pulses one cycle after the last counted cycle
`timescale 1ns/10ps
module irf_delay_timer #(
	parameter int CW = 11
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Control
	input  wire logic          start,
	input  wire logic [CW-1:0] load,
	// Status
	output logic               busy,
	output logic               done
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          busy;
		logic          done;
	} irf_tmr_t;

	irf_tmr_t s_q;
	irf_tmr_t s_d;

	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (start) begin
			s_d.cnt  = load;
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			if (s_q.cnt <= CW'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
				s_d.cnt  = '0;
			end else begin
				s_d.cnt = s_q.cnt - CW'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy = s_q.busy;
	assign done = s_q.done;
endmodule : irf_delay_timer

// File: design/irf_idle_ctrl.sv
// Purpose: Idle mode entry and wake sequencing with reset cause flags
// Assumes: Core gives one-cycle pulses for sleep and watchdog clear
// Notes:   aresetn acts as the power-on reset of this block
// Notes on behaviour
// - Primary idle: CPU off, peripherals on primary
// - Primary idle wake: CPU on primary after delay
// - Secondary idle: primary off, secondary status set
// - Secondary idle wake: stay on secondary oscillator
// - Secondary disabled ignores sleep; wait until running
// - Internal idle: peripherals on internal, primary off
// - Internal oscillator kept by watchdog or monitor
// - Wake only on interrupt, reset, watchdog
// - Enabled interrupt flag starts the exit
// - Branch to vector only if global enable
// - Fixed start delay, then execution resumes
// - Watchdog wakes when idle, resets when running
// - Sleep, clear, clock loss clear watchdog
// - Reset exit runs from internal oscillator
// - No start-up timer for primary idle or external
// - Bit 7 priority enable, bit 6 reads zero
// - Mismatch reset clears bit 5
// - Reset instruction clears bit 4
// - Bit 3 read-only timeout flag
// - Bit 2 read-only power-down flag
// - Power-on reset clears bit 1
// - Brown-out clears bit 0; held without regulator
// - Power-on flag untouched by other resets
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module irf_idle_ctrl
	import irf_pkg::*;
#(
	parameter int OST_CYCLES = irf_pkg::OST_CYC,
	parameter int NIRQ       = 8
) (
	// Clock and reset
	input  wire logic            aclk,
	input  wire logic            aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]      s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Core events
	input  wire logic            sleep_instr,
	input  wire logic            watchdog_clear_instr,
	input  wire logic            global_irq_enable,
	input  wire logic [NIRQ-1:0] irq_flags,
	input  wire logic [NIRQ-1:0] irq_enables,
	// Reset and watchdog events
	input  wire logic            wdt_timeout,
	input  wire logic            clock_loss,
	input  wire logic            mclr_reset,
	input  wire logic            brownout_reset,
	input  wire logic            config_mismatch_reset,
	input  wire logic            reset_instr,
	input  wire logic            regulator_enable,
	// Oscillator status
	input  wire logic            secondary_osc_ready,
	// Clock control
	output logic                 cpu_clk_en,
	output logic                 periph_clk_en,
	output logic [1:0]           periph_clk_sel,
	output logic                 primary_osc_en,
	output logic                 internal_osc_en,
	output logic                 primary_clock_status,
	output logic                 secondary_osc_running,
	output logic                 irq_priority_enable,
	// Core control
	output logic                 cpu_resume,
	output logic                 branch_to_vector,
	output logic                 wdt_clear,
	output logic                 wdt_reset_req
);
	import irf_pkg::*;

	typedef struct packed {
		irf_mode_t   mode;
		irf_src_t    src;
		logic        irq_wake;
		logic [7:0]  rctl;
		logic [7:0]  pctl;
		logic        resume;
		logic        branch;
		logic        wclr;
		logic        wrst;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} irf_state_t;

	irf_state_t s_q;
	irf_state_t s_d;

	logic             tmr_start;
	logic [TMR_W-1:0] tmr_load;
	logic             tmr_busy;
	logic             tmr_done;
	logic             wr_go;
	logic             low_power;
	logic             irq_hit;
	logic             wake;
	logic             hw_reset;
	logic [1:0]       system_clock_select;
	logic [1:0]       primary_osc_config;

	// Register select: 0 reset ctrl, 1 power ctrl, 2 status, 3 none
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		logic [1:0] r;
		r = 2'h3;
		if (addr == RCTL_OFS) begin
			r = 2'h0;
		end else if (addr == PCTL_OFS) begin
			r = 2'h1;
		end else if (addr == STAT_OFS) begin
			r = 2'h2;
		end
		return r;
	endfunction : reg_sel

	// Clock source for a select code
	function automatic irf_src_t scs_src(input logic [1:0] sel);
		irf_src_t r;
		r = SRC_RC;
		if (sel == SCS_PRI) begin
			r = SRC_PRI;
		end else if (sel == SCS_SEC) begin
			r = SRC_SEC;
		end
		return r;
	endfunction : scs_src

	irf_delay_timer #(
		.CW (TMR_W)
	) u_tmr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (tmr_start),
		.load    (tmr_load),
		.busy    (tmr_busy),
		.done    (tmr_done)
	);

	assign system_clock_select       = s_q.pctl[PC_SCS_LSB +: 2];
	assign primary_osc_config      = s_q.pctl[PC_PRIMARY_OSC_CONFIG_LSB +: 2];
	assign low_power = (s_q.mode == M_IDLE) || (s_q.mode == M_SLEEP) ||
		(s_q.mode == M_SEC_WAIT);
	assign irq_hit   = |(irq_flags & irq_enables);
	assign wake      = low_power && (irq_hit || wdt_timeout);
	assign hw_reset  = mclr_reset || brownout_reset || config_mismatch_reset ||
		reset_instr;
	assign wr_go     = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;

	always_comb begin
		s_d        = s_q;
		s_d.resume = 1'b0;
		s_d.branch = 1'b0;
		s_d.wclr   = 1'b0;
		s_d.wrst   = 1'b0;
		tmr_start  = 1'b0;
		tmr_load   = TMR_W'(CSD_CYC);

		// Software register writes
		if (wr_go) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = RESP_OKAY;
			case (reg_sel(s_axi_awaddr))
				2'h0: begin
					if (s_axi_wstrb[0]) begin
						s_d.rctl = (s_q.rctl & ~RCTL_WMASK) |
							(s_axi_wdata[7:0] & RCTL_WMASK);
					end
				end
				2'h1: begin
					if (s_axi_wstrb[0]) begin
						s_d.pctl = s_axi_wdata[7:0];
					end
				end
				2'h2: begin
					s_d.bresp = RESP_OKAY;
				end
				default: begin
					s_d.bresp = RESP_SLVERR;
				end
			endcase
		end else if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// Register reads
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				2'h0: s_d.rdata = {24'h000000, s_q.rctl};
				2'h1: s_d.rdata = {24'h000000, s_q.pctl};
				2'h2: s_d.rdata = {24'h000000, tmr_busy, secondary_osc_running,
					primary_clock_status, s_q.src, s_q.mode};
				default: begin
					s_d.rdata = 32'h00000000;
					s_d.rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Mode sequencing
		case (s_q.mode)
			M_RUN: begin
				if (sleep_instr) begin
					s_d.wclr = 1'b1;
					if (!s_q.pctl[PC_IDLE_ON_SLEEP_SELECT]) begin
						s_d.mode = M_SLEEP;
					end else if (system_clock_select == SCS_PRI) begin
						s_d.mode = M_IDLE;
						s_d.src  = SRC_PRI;
					end else if (system_clock_select == SCS_SEC) begin
						if (s_q.pctl[PC_SOSC_EN]) begin
							s_d.src  = SRC_SEC;
							s_d.mode = secondary_osc_ready ? M_IDLE : M_SEC_WAIT;
						end
					end else begin
						s_d.mode = M_IDLE;
						s_d.src  = SRC_RC;
					end
				end else if (wdt_timeout) begin
					s_d.wrst = 1'b1;
				end
			end
			M_SEC_WAIT, M_IDLE, M_SLEEP: begin
				if (wake) begin
					s_d.irq_wake = irq_hit;
					if (s_q.mode == M_SLEEP) begin
						s_d.src = scs_src(system_clock_select);
					end
					if ((s_q.mode == M_SLEEP) && (scs_src(system_clock_select) == SRC_PRI) &&
						(primary_osc_config != PRIMARY_OSC_CONFIG_EC) && (primary_osc_config != PRIMARY_OSC_CONFIG_EXTERNAL_CLOCK_PLL_MODE)) begin
						s_d.mode  = M_OST;
						tmr_start = 1'b1;
						tmr_load  = TMR_W'(OST_CYCLES);
					end else begin
						s_d.mode  = M_CSD;
						tmr_start = 1'b1;
					end
				end else if ((s_q.mode == M_SEC_WAIT) && secondary_osc_ready) begin
					s_d.mode = M_IDLE;
				end
			end
			M_OST: begin
				if (tmr_done) begin
					s_d.mode  = M_CSD;
					tmr_start = 1'b1;
				end
			end
			M_CSD: begin
				if (tmr_done) begin
					s_d.mode   = M_RUN;
					s_d.resume = 1'b1;
					s_d.branch = s_q.irq_wake && global_irq_enable;
				end
			end
			default: begin
				s_d.mode = M_RUN;
			end
		endcase

		// Reset ends any low power mode on the internal oscillator
		if (hw_reset && (s_q.mode != M_RUN)) begin
			s_d.mode   = M_RUN;
			s_d.src    = SRC_RC;
			s_d.resume = 1'b0;
			s_d.branch = 1'b0;
		end

		// Watchdog clear on instruction or lost clock
		if (watchdog_clear_instr || (s_q.pctl[PC_FSCM_EN] && clock_loss)) begin
			s_d.wclr = 1'b1;
		end

		// Hardware flag updates win over software writes
		if (watchdog_clear_instr) begin
			s_d.rctl[BIT_TO] = 1'b1;
			s_d.rctl[BIT_PD] = 1'b1;
		end
		if (sleep_instr && (s_q.mode == M_RUN)) begin
			s_d.rctl[BIT_TO] = 1'b1;
			s_d.rctl[BIT_PD] = 1'b0;
		end
		if (wdt_timeout) begin
			s_d.rctl[BIT_TO] = 1'b0;
		end
		if (config_mismatch_reset) begin
			s_d.rctl[BIT_CM] = 1'b0;
		end
		if (reset_instr) begin
			s_d.rctl[BIT_RI] = 1'b0;
		end
		if (brownout_reset || !regulator_enable) begin
			s_d.rctl[BIT_BOR] = 1'b0;
		end
		s_d.rctl[6] = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q      <= '0;
			s_q.mode <= M_RUN;
			s_q.src  <= SRC_PRI;
			s_q.rctl <= RCTL_RST;
			s_q.pctl <= PCTL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Bus handshakes
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rresp   = s_q.rresp;
	assign s_axi_rdata   = s_q.rdata;

	// Clock gating and status
	assign cpu_clk_en            = (s_q.mode == M_RUN);
	assign periph_clk_en         = (s_q.mode == M_RUN) || (s_q.mode == M_IDLE) ||
		(s_q.mode == M_CSD);
	assign periph_clk_sel        = s_q.src;
	assign primary_osc_en        = ((s_q.src == SRC_PRI) && (s_q.mode != M_SLEEP)) ||
		(s_q.mode == M_OST);
	assign internal_osc_en       = ((s_q.src == SRC_RC) && (s_q.mode != M_SLEEP)) ||
		s_q.pctl[PC_WDT_EN] || s_q.pctl[PC_FSCM_EN];
	assign primary_clock_status  = (s_q.src == SRC_PRI) && (s_q.mode != M_SLEEP) &&
		(s_q.mode != M_OST);
	assign secondary_osc_running = (s_q.src == SRC_SEC) && (s_q.mode != M_SLEEP);
	assign irq_priority_enable   = s_q.rctl[BIT_IRQ_PRIORITY_ENABLE];
	assign cpu_resume            = s_q.resume;
	assign branch_to_vector      = s_q.branch;
	assign wdt_clear             = s_q.wclr;
	assign wdt_reset_req         = s_q.wrst;
endmodule : irf_idle_ctrl

// File: verification/irf_idle_ctrl_monitor.sv
// Purpose: Port-level checks on the idle controller
// Assumes: Bound to irf_idle_ctrl, one clock domain
// Notes:   Wake timing tied to the package start delay
`timescale 1ns/10ps
module irf_idle_ctrl_monitor
	import irf_pkg::*;
(
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Core and reset events
	input logic        sleep_instr,
	input logic        watchdog_clear_instr,
	input logic        global_irq_enable,
	input logic        wdt_timeout,
	input logic        mclr_reset,
	input logic        secondary_osc_ready,
	// Clock and core control
	input logic        cpu_clk_en,
	input logic        periph_clk_en,
	input logic [1:0]  periph_clk_sel,
	input logic        primary_clock_status,
	input logic        secondary_osc_running,
	input logic        cpu_resume,
	input logic        branch_to_vector,
	input logic        wdt_clear,
	input logic        wdt_reset_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// CPU stopped, peripherals clocked from sel
	sequence s_idle_on(logic [1:0] sel);
		!cpu_clk_en && periph_clk_en && periph_clk_sel == sel;
	endsequence

	chk_prim_idle: assert property (s_idle_on(SCS_PRI) |-> primary_clock_status)
		else $error("primary status lost in primary idle");
	chk_secondary_idle: assert property (s_idle_on(SCS_SEC) |->
		!primary_clock_status && secondary_osc_running)
		else $error("status wrong in secondary idle");
	chk_internal_osc_idle: assert property (s_idle_on(SCS_RC) |-> !primary_clock_status)
		else $error("primary status set in internal idle");
	chk_sec_wait: assert property (!cpu_clk_en && periph_clk_sel == SCS_SEC &&
		!secondary_osc_ready |-> !periph_clk_en)
		else $error("peripherals clocked before oscillator runs");
	chk_wdt_action: assert property (wdt_timeout |=> wdt_reset_req == $past(cpu_clk_en))
		else $error("watchdog action wrong for mode");
	chk_wdt_clear: assert property (watchdog_clear_instr || sleep_instr && cpu_clk_en |=>
		wdt_clear)
		else $error("watchdog not cleared");
	chk_resume_gap: assert property (cpu_resume |-> !$past(cpu_clk_en, CSD_CYC))
		else $error("execution resumed before start delay");
	chk_branch_gie: assert property (branch_to_vector |->
		cpu_resume && $past(global_irq_enable))
		else $error("branch without global enable");
	chk_reset_exit: assert property (mclr_reset && !cpu_clk_en |=>
		cpu_clk_en && periph_clk_sel == SCS_RC)
		else $error("reset exit not on internal clock");
endmodule : irf_idle_ctrl_monitor

// File: verification/tb.sv
// Purpose: Self-checking bench for the idle controller
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes:   Start-up timer shortened through OST_CYCLES
`timescale 1ns/10ps
module tb;
	import irf_pkg::*;
	localparam int OSTN = 32;
	localparam int E_SLP = 0, E_CLR = 1, E_WDT = 2, E_LOSS = 3;
	localparam int E_MCLR = 4, E_BOR = 5, E_CM = 6, E_RI = 7;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rmask = 32'hffffffff;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, periph_clk_sel;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        sleep_instr = 1'b0, watchdog_clear_instr = 1'b0, global_irq_enable = 1'b0;
	logic        wdt_timeout = 1'b0, clock_loss = 1'b0, mclr_reset = 1'b0, brownout_reset = 1'b0;
	logic        config_mismatch_reset = 1'b0, reset_instr = 1'b0, regulator_enable = 1'b1;
	logic        secondary_osc_ready = 1'b0, clr_seen, rst_seen;
	logic [7:0]  irq_flags = 8'h81, irq_enables = 8'h00;
	logic        cpu_clk_en, periph_clk_en, primary_osc_en, internal_osc_en;
	logic        primary_clock_status, secondary_osc_running, irq_priority_enable;
	logic        cpu_resume, branch_to_vector, wdt_clear, wdt_reset_req;
	int          mismatches = 0, total_checks = 0;

	always #2 aclk = ~aclk;

	irf_idle_ctrl #(.OST_CYCLES(OSTN)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr, .watchdog_clear_instr,
		.global_irq_enable, .irq_flags, .irq_enables, .wdt_timeout, .clock_loss, .mclr_reset,
		.brownout_reset, .config_mismatch_reset, .reset_instr, .regulator_enable,
		.secondary_osc_ready, .cpu_clk_en, .periph_clk_en, .periph_clk_sel, .primary_osc_en,
		.internal_osc_en, .primary_clock_status, .secondary_osc_running, .irq_priority_enable,
		.cpu_resume, .branch_to_vector, .wdt_clear, .wdt_reset_req);

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic hang(input string nm);
		check(nm, 32'h1, 32'h0);
		stop_test();
	endtask : hang

	// Clock enables, source and status bits
	task automatic clk(input logic [6:0] e);
		check("clock state", {25'h0, e}, {25'h0, cpu_clk_en, periph_clk_en, periph_clk_sel,
			primary_osc_en, primary_clock_status, secondary_osc_running});
	endtask : clk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(s_axi_awready && s_axi_wready) && n < 50);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		s_axi_bready <= 1'b0;
		if (n >= 50)
			hang("write handshake");
		check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!s_axi_arready && n < 50);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid && n < 50) begin
			@(posedge aclk);
			n++;
		end
		s_axi_rready <= 1'b0;
		if (n >= 50)
			hang("read handshake");
		check("rdata", ed, s_axi_rdata & rmask);
		check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask : rd

	// One-cycle event pulse, then settled pulse outputs
	task automatic ev(input int k);
		@(posedge aclk);
		case (k)
			E_SLP: sleep_instr <= 1'b1;
			E_CLR: watchdog_clear_instr <= 1'b1;
			E_WDT: wdt_timeout <= 1'b1;
			E_LOSS: clock_loss <= 1'b1;
			E_MCLR: mclr_reset <= 1'b1;
			E_BOR: brownout_reset <= 1'b1;
			E_CM: config_mismatch_reset <= 1'b1;
			default: reset_instr <= 1'b1;
		endcase
		@(posedge aclk);
		{sleep_instr, watchdog_clear_instr, wdt_timeout, clock_loss, mclr_reset,
			brownout_reset, config_mismatch_reset, reset_instr} <= 8'h00;
		#1;
		clr_seen = wdt_clear;
		rst_seen = wdt_reset_req;
	endtask : ev

	// Enable pending flags, count cycles up to execution resume
	task automatic wake(input logic [7:0] e, input int lo, input int hi, input logic br);
		int n;
		@(posedge aclk);
		irq_enables <= e;
		n = 0;
		while (!cpu_resume && n < 2000) begin
			@(posedge aclk);
			#1;
			n++;
		end
		if (n >= 2000)
			hang("resume");
		check("wake window", 32'h1, {31'h0, n >= lo && n <= hi});
		check("branch", {31'h0, br}, {31'h0, branch_to_vector});
		@(posedge aclk);
		irq_enables <= 8'h00;
	endtask : wake

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(RCTL_OFS, 32'h3c, RESP_OKAY);
		rd(PCTL_OFS, {24'h0, PCTL_RST}, RESP_OKAY);
		wr(RCTL_OFS, 32'hff, RESP_OKAY);
		rd(RCTL_OFS, 32'hbf, RESP_OKAY);
		check("priority", 32'h1, {31'h0, irq_priority_enable});
		wr(RCTL_OFS, 32'h00, RESP_OKAY);
		rd(RCTL_OFS, 32'h0c, RESP_OKAY);
		wr(STAT_OFS, 32'hff, RESP_OKAY);
		rd(8'h0c, 32'h0, RESP_SLVERR);
		wr(RCTL_OFS, 32'h33, RESP_OKAY);
		ev(E_CM);
		ev(E_RI);
		ev(E_BOR);
		rd(RCTL_OFS, 32'h0e, RESP_OKAY);
		regulator_enable <= 1'b0;
		wr(RCTL_OFS, 32'h03, RESP_OKAY);
		rd(RCTL_OFS, 32'h0e, RESP_OKAY);
		regulator_enable <= 1'b1;
		ev(E_WDT);
		check("wdt reset", 32'h1, {31'h0, rst_seen});
		rd(RCTL_OFS, 32'h06, RESP_OKAY);
		ev(E_CLR);
		check("wdt clear", 32'h1, {31'h0, clr_seen});
		rd(RCTL_OFS, 32'h0e, RESP_OKAY);
		wr(PCTL_OFS, 32'h06, RESP_OKAY);
		ev(E_SLP);
		repeat (20) @(posedge aclk);
		clk(7'b0110110);
		rd(RCTL_OFS, 32'h0a, RESP_OKAY);
		global_irq_enable <= 1'b1;
		wake(8'h01, CSD_CYC, CSD_CYC + 6, 1'b1);
		clk(7'b1110110);
		rd(PCTL_OFS, 32'h06, RESP_OKAY);
		for (int i = 0; i < 2; i++) begin
			wr(PCTL_OFS, {24'h0, (i == 0) ? PRIMARY_OSC_CONFIG_EC : PRIMARY_OSC_CONFIG_EXTERNAL_CLOCK_PLL_MODE, 6'h02}, RESP_OKAY);
			ev(E_SLP);
			wake(8'h01, CSD_CYC, CSD_CYC + 6, 1'b1);
		end
		wr(PCTL_OFS, 32'h02, RESP_OKAY);
		ev(E_SLP);
		wake(8'h01, OSTN, OSTN + 20, 1'b1);
		global_irq_enable <= 1'b0;
		wr(PCTL_OFS, 32'h05, RESP_OKAY);
		ev(E_SLP);
		check("ignored sleep", 32'h1, {31'h0, cpu_clk_en});
		wr(PCTL_OFS, 32'h0d, RESP_OKAY);
		ev(E_SLP);
		repeat (4) @(posedge aclk);
		check("periph clock", 32'h0, {31'h0, periph_clk_en});
		secondary_osc_ready <= 1'b1;
		repeat (4) @(posedge aclk);
		clk(7'b0101001);
		ev(E_WDT);
		check("wdt reset", 32'h0, {31'h0, rst_seen});
		wake(8'h00, 0, CSD_CYC + 6, 1'b0);
		clk(7'b1101001);
		wr(PCTL_OFS, 32'h14, RESP_OKAY);
		ev(E_SLP);
		clk(7'b0100000);
		wake(8'h80, CSD_CYC, CSD_CYC + 6, 1'b0);
		check("internal osc", 32'h1, {31'h0, internal_osc_en});
		wr(PCTL_OFS, 32'h26, RESP_OKAY);
		ev(E_LOSS);
		check("loss clear", 32'h1, {31'h0, clr_seen});
		ev(E_SLP);
		check("internal osc", 32'h1, {31'h0, internal_osc_en});
		ev(E_MCLR);
		clk(7'b1100000);
		rmask = 32'h02;
		rd(RCTL_OFS, 32'h02, RESP_OKAY);
		rmask = 32'hffffffff;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(RCTL_OFS, 32'h3c, RESP_OKAY);
		stop_test();
	end
endmodule : tb

bind irf_idle_ctrl irf_idle_ctrl_monitor u_mon (.aclk, .aresetn, .sleep_instr,
	.watchdog_clear_instr, .global_irq_enable, .wdt_timeout, .mclr_reset, .secondary_osc_ready,
	.cpu_clk_en, .periph_clk_en, .periph_clk_sel, .primary_clock_status, .secondary_osc_running,
	.cpu_resume, .branch_to_vector, .wdt_clear, .wdt_reset_req);
